//--- inc/sbf_pkg.sv
// sbf_pkg: constants and types of the serial bcd frequency register
// assumes one 25 MHz core clock; shared by the register and the testbench
package sbf_pkg;
    localparam int CLK_HZ         = 25_000_000;
    localparam int STEP_TIME_NS   = 400;
    localparam int STEP_DIV       = (STEP_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int STEPS_PER_CYC  = 18;
    localparam int SERIAL_STEPS   = 9;
    localparam int NUM_DIGITS     = 9;
    localparam int GHZ_DIGIT      = 6;
    localparam int TEN_GHZ_DIGIT  = 7;
    localparam int HUNDRED_DIGIT  = 8;
    localparam logic [3:0] PRESET_GHZ = 4'h3;
    localparam logic [3:0] LOW_GHZ    = 4'h2;
    localparam logic [3:0] BAND_LO_G  = 4'h6;
    localparam logic [3:0] BAND_HI_G  = 4'h2;
    localparam int FIFO_WIDTH     = 4;
    localparam int FIFO_DEPTH     = 16;

    typedef enum logic [1:0] {
        SBF_IDLE  = 2'b00,
        SBF_SHIFT = 2'b01,
        SBF_TAIL  = 2'b10
    } sbf_phase_e;
endpackage : sbf_pkg

//--- rtl/sbf_fifo.sv
// sbf_fifo: small synchronous fifo, flip-flop storage
// assumes one clock and synchronous active-high reset
module sbf_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             wr, rd;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    always_comb begin
        wp_nxt  = wr ? wp_r + 1'b1 : wp_r;
        rp_nxt  = rd ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (wr) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule : sbf_fifo

//--- rtl/sbf_freq_reg.sv
// sbf_freq_reg: nine-digit bcd frequency store with serial recirculation
// assumes inputs synchronous to core_clk; sink drains the digit fifo
module sbf_freq_reg
    import sbf_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       preset_key,
    input  wire logic       clock_enable,
    input  wire logic       step_pulse,
    input  wire logic       continuous,
    input  wire logic       limit_suppress,
    input  wire logic       knob_detent,
    input  wire logic       knob_ccw,
    input  wire logic [3:0] resolution,
    input  wire logic       sink_ready,
    output logic            phase_clk,
    output logic            clear,
    output logic            serial_out_w1,
    output logic            serial_out_w2,
    output logic            serial_out_w4,
    output logic            serial_out_w8,
    output logic            serial_valid,
    output logic [3:0]      sink_digit,
    output logic            sink_valid,
    output logic            knob_direction,
    output logic            range_error,
    output logic            decode_error_n,
    output logic            band_raw_lo,
    output logic            band_raw_hi,
    output logic            band_code_lo,
    output logic            band_code_hi,
    output logic [4:0]      step_index
);
    import sbf_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // step timing
    logic [15:0] div_r, div_nxt;
    logic        step_en;
    logic [4:0]  step_r, step_nxt;
    logic        fifo_ready;

    always_comb begin
        div_nxt = div_r;
        step_en = 1'b0;
        if (clock_enable) begin
            if (div_r == 16'(STEP_DIV - 1)) begin
                div_nxt = '0;
                step_en = fifo_ready;
            end else begin
                div_nxt = div_r + 16'h0001;
            end
        end else begin
            div_nxt = '0;
            step_en = step_pulse && fifo_ready;
        end
    end

    always_comb begin
        step_nxt = step_r;
        if (step_en) begin
            if (step_r == 5'(STEPS_PER_CYC - 1)) begin
                step_nxt = '0;
            end else begin
                step_nxt = step_r + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_r  <= '0;
            step_r <= '0;
        end else begin
            div_r  <= div_nxt;
            step_r <= step_nxt;
        end
    end

    // phase clock high during the nine serial steps
    assign phase_clk  = (step_r < 5'(SERIAL_STEPS));
    assign step_index = step_r;

    ////////////////////////////////////////////////////////////////////
    // digit store, knob adder, preset
    logic [3:0] dig_r [NUM_DIGITS];
    logic [3:0] dig_nxt [NUM_DIGITS];
    logic       tune_pend_r, tune_pend_nxt;
    logic       tune_dn_r, tune_dn_nxt;
    logic       hold_r, hold_nxt;
    logic       cyc_end, cyc_start;
    logic [3:0] sel_dig;

    assign cyc_end   = step_en && (step_r == 5'(STEPS_PER_CYC - 1));
    assign cyc_start = cyc_end;
    assign clear     = preset_key;
    assign knob_direction = knob_ccw;

    always_comb begin
        sel_dig = 4'h0;
        for (int i = 0; i < NUM_DIGITS; i++) begin
            if (resolution == 4'(i)) begin
                sel_dig = dig_r[i];
            end
        end
    end

    always_comb begin
        tune_pend_nxt = tune_pend_r;
        tune_dn_nxt   = tune_dn_r;
        hold_nxt      = hold_r;
        for (int i = 0; i < NUM_DIGITS; i++) begin
            dig_nxt[i] = dig_r[i];
        end
        if (knob_detent) begin
            tune_pend_nxt = 1'b1;
            tune_dn_nxt   = knob_ccw;
        end
        if (cyc_start) begin
            hold_nxt = preset_key;
        end else if (!preset_key) begin
            hold_nxt = 1'b0;
        end
        if (preset_key) begin
            // clear acts at once; a held cycle re-forces it
            for (int i = 0; i < NUM_DIGITS; i++) begin
                dig_nxt[i] = 4'h0;
            end
            dig_nxt[GHZ_DIGIT] = PRESET_GHZ;
            tune_pend_nxt = 1'b0;
        end else if (cyc_end && tune_pend_r && continuous) begin
            // plus/minus one applied at the selected digit
            if (tune_dn_r) begin
                dig_nxt[resolution] = (sel_dig == 4'h0) ? 4'h9
                                      : sel_dig - 4'h1;
            end else begin
                dig_nxt[resolution] = (sel_dig == 4'h9) ? 4'h0
                                      : sel_dig + 4'h1;
            end
            // a detent in the applying cycle stays pending
            tune_pend_nxt = knob_detent;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_DIGITS; i++) begin
                dig_r[i] <= 4'h0;
            end
            dig_r[GHZ_DIGIT] <= PRESET_GHZ;
            tune_pend_r <= 1'b0;
            tune_dn_r   <= 1'b0;
            hold_r      <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_DIGITS; i++) begin
                dig_r[i] <= dig_nxt[i];
            end
            tune_pend_r <= tune_pend_nxt;
            tune_dn_r   <= tune_dn_nxt;
            hold_r      <= hold_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // serial output lanes, lsd first
    logic [3:0] lane_r, lane_nxt;
    logic       sval_r, sval_nxt;

    always_comb begin
        lane_nxt = 4'h0;
        sval_nxt = 1'b0;
        if (step_r < 5'(SERIAL_STEPS) && continuous) begin
            lane_nxt = dig_r[step_r[3:0]];
            sval_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lane_r <= 4'h0;
            sval_r <= 1'b0;
        end else begin
            lane_r <= lane_nxt;
            sval_r <= sval_nxt;
        end
    end

    assign serial_out_w1 = lane_r[0];
    assign serial_out_w2 = lane_r[1];
    assign serial_out_w4 = lane_r[2];
    assign serial_out_w8 = lane_r[3];
    assign serial_valid  = sval_r;

    sbf_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_data   (lane_nxt),
        .in_valid  (step_en && sval_nxt),
        .in_ready  (fifo_ready),
        .out_data  (sink_digit),
        .out_valid (sink_valid),
        .out_ready (sink_ready)
    );

    ////////////////////////////////////////////////////////////////////
    // decode: range and band
    logic high_zero, below_2g, err_r, err_nxt;
    logic raw_lo, raw_hi;
    logic blo_r, blo_nxt, bhi_r, bhi_nxt;

    assign high_zero = (dig_r[TEN_GHZ_DIGIT] == 4'h0)
                       && (dig_r[HUNDRED_DIGIT] == 4'h0);
    assign below_2g  = high_zero && (dig_r[GHZ_DIGIT] < LOW_GHZ);
    // band 1 from 6 GHz, band 2 from 12 GHz
    assign raw_lo = !raw_hi && (dig_r[TEN_GHZ_DIGIT] != 4'h0
                    || dig_r[GHZ_DIGIT] >= BAND_LO_G);
    assign raw_hi = (dig_r[TEN_GHZ_DIGIT] != 4'h0)
                    && (dig_r[GHZ_DIGIT] >= BAND_HI_G
                    || dig_r[TEN_GHZ_DIGIT] > 4'h1);

    always_comb begin
        err_nxt = below_2g && !limit_suppress;
        blo_nxt = blo_r;
        bhi_nxt = bhi_r;
        if (cyc_end) begin
            blo_nxt = raw_lo;
            bhi_nxt = raw_hi;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            err_r <= 1'b0;
            blo_r <= 1'b0;
            bhi_r <= 1'b0;
        end else begin
            err_r <= err_nxt;
            blo_r <= blo_nxt;
            bhi_r <= bhi_nxt;
        end
    end

    assign range_error    = err_r;
    assign decode_error_n = !err_r;
    assign band_raw_lo    = raw_lo;
    assign band_raw_hi    = raw_hi;
    assign band_code_lo   = blo_r;
    assign band_code_hi   = bhi_r;
endmodule : sbf_freq_reg

//--- verification/sbf_freq_reg_monitor.sv
// sbf_freq_reg_monitor: port assertions
// assumes a bind onto sbf_freq_reg
module sbf_freq_reg_monitor (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       preset_key,
    input wire logic       clear,
    input wire logic       knob_ccw,
    input wire logic       knob_direction,
    input wire logic       clock_enable,
    input wire logic       step_pulse,
    input wire logic       phase_clk,
    input wire logic [4:0] step_index,
    input wire logic       limit_suppress,
    input wire logic       range_error,
    input wire logic       band_code_lo,
    input wire logic       band_code_hi
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    clear_follow_a: assert property (clear == preset_key)
        else $error("clear differs from key");
    dir_follow_a: assert property (knob_direction == knob_ccw)
        else $error("direction differs from knob");
    phase_window_a: assert property (phase_clk == (step_index < 5'd9))
        else $error("phase clock off window");
    step_order_a: assert property ($changed(step_index) |->
        step_index == ($past(step_index) == 5'd17 ? 5'd0
            : $past(step_index) + 5'd1)) else $error("step order");
    step_space_a: assert property (clock_enable && $changed(step_index)
        |=> $stable(step_index) [*8]) else $error("step too soon");
    halt_hold_a: assert property (!clock_enable && !$past(clock_enable)
        && !step_pulse && !$past(step_pulse) |=> $stable(step_index))
        else $error("step while halted");
    suppress_low_a: assert property (limit_suppress [*2] |-> !range_error)
        else $error("error while suppressed");
    band_latch_a: assert property ($changed({band_code_lo, band_code_hi})
        |-> step_index <= 5'd1) else $error("band changed mid cycle");
endmodule : sbf_freq_reg_monitor

bind sbf_freq_reg sbf_freq_reg_monitor mon (.core_clk, .rst, .preset_key,
    .clear, .knob_ccw, .knob_direction, .clock_enable, .step_pulse,
    .phase_clk, .step_index, .limit_suppress, .range_error, .band_code_lo,
    .band_code_hi);

//--- verification/sbf_sink_model.sv
// sbf_sink_model: downstream register draining the digit fifo
// assumes core_clk domain; stall holds ready low
module sbf_sink_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [3:0] sink_digit,
    input  wire logic       sink_valid,
    output logic            sink_ready,
    input  wire logic       stall
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] rx [0:8];
    int         cnt;
    ////////////////////////////////////////
    assign sink_ready = !stall;
    always @(posedge core_clk) begin
        if (rst) begin
            cnt <= 0;
        end else if (sink_valid && sink_ready) begin
            rx[cnt % 9] <= sink_digit;
            cnt <= cnt + 1;
        end
    end
endmodule : sbf_sink_model

//--- verification/testbench.sv
// testbench: directed checks of the frequency register
// assumes sbf_sink_model drains the digit fifo
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sbf_pkg::*;
    logic core_clk = 0, rst = 1, preset_key = 0, clock_enable = 1, stall = 0;
    logic step_pulse = 0, continuous = 1, limit_suppress = 0, knob_ccw = 0;
    logic knob_detent = 0, sink_ready, phase_clk, clear, sink_valid;
    logic [3:0] resolution = 4'h0, sink_digit;
    logic serial_out_w1, serial_out_w2, serial_out_w4, serial_out_w8;
    logic knob_direction, range_error, band_code_lo, band_code_hi;
    logic serial_valid, decode_error_n, band_raw_lo, band_raw_hi;
    logic [4:0] step_index, last;
    logic [3:0] exp_d [0:8];
    int fail_count = 0, checks = 0, cycles = 0;
    ////////////////////////////////////////
    sbf_freq_reg uut (.core_clk, .rst, .preset_key, .clock_enable,
        .step_pulse, .continuous, .limit_suppress, .knob_detent, .knob_ccw,
        .resolution, .sink_ready, .phase_clk, .clear, .serial_out_w1,
        .serial_out_w2, .serial_out_w4, .serial_out_w8, .serial_valid,
        .sink_digit, .sink_valid, .knob_direction, .range_error,
        .decode_error_n, .band_raw_lo, .band_raw_hi, .band_code_lo,
        .band_code_hi, .step_index);
    sbf_sink_model partner (.core_clk, .rst, .sink_digit, .sink_valid,
        .sink_ready, .stall);
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            give_verdict();
        end
    end
    ////////////////////////////////////////
    task automatic give_verdict;
        if (fail_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [4:0] e, s);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, e, s);
        end
    endtask : check
    task automatic wait_step(input logic [4:0] k);
        while (step_index !== k) @(negedge core_clk);
    endtask : wait_step
    task automatic wait_wrap;
        wait_step(5'd17);
        wait_step(5'd0);
    endtask : wait_wrap
    task automatic read_freq;
        wait_wrap();
        for (int k = 0; k < 9; k++) begin
            wait_step(k[4:0]);
            repeat (2) @(negedge core_clk);
            check("lanes", {1'b0, exp_d[k]}, {1'b0, serial_out_w8,
                serial_out_w4, serial_out_w2, serial_out_w1});
            check("valid", 5'h01, {4'h0, serial_valid});
            check("phase", 5'h01, {4'h0, phase_clk});
        end
    endtask : read_freq
    task automatic tune(input int r, input logic ccw, input int n);
        repeat (n) begin
            resolution = r[3:0];
            knob_ccw = ccw;
            knob_detent = 1;
            @(negedge core_clk);
            knob_detent = 0;
            if (ccw) exp_d[r] = exp_d[r] == 4'h0 ? 4'h9 : exp_d[r] - 4'h1;
            else exp_d[r] = exp_d[r] == 4'h9 ? 4'h0 : exp_d[r] + 4'h1;
            wait_wrap();
        end
    endtask : tune
    task automatic preset_exp;
        for (int k = 0; k < NUM_DIGITS; k++) exp_d[k] = 4'h0;
        exp_d[GHZ_DIGIT] = PRESET_GHZ;
    endtask : preset_exp
    ////////////////////////////////////////
    initial begin
        preset_exp();
        repeat (16) @(negedge core_clk);
        rst = 0;
        read_freq();
        for (int r = 0; r < NUM_DIGITS; r++) begin
            tune(r, 1'b0, 1);
            read_freq();
            tune(r, 1'b1, 1);
            read_freq();
        end
        check("direction", 5'h01, {4'h0, knob_direction});
        tune(GHZ_DIGIT, 1'b1, 1);
        wait_wrap();
        check("bands", 5'h00, {3'h0, band_code_hi, band_code_lo});
        check("raw bands", 5'h00, {3'h0, band_raw_hi, band_raw_lo});
        tune(GHZ_DIGIT, 1'b1, 1);
        wait_wrap();
        check("range", 5'h01, {4'h0, range_error});
        check("error n", 5'h00, {4'h0, decode_error_n});
        limit_suppress = 1;
        repeat (3) @(negedge core_clk);
        check("range", 5'h00, {4'h0, range_error});
        limit_suppress = 0;
        tune(GHZ_DIGIT, 1'b1, 1);
        tune(TEN_GHZ_DIGIT, 1'b0, 1);
        wait_wrap();
        check("bands", 5'h01, {3'h0, band_code_hi, band_code_lo});
        check("raw bands", 5'h01, {3'h0, band_raw_hi, band_raw_lo});
        tune(GHZ_DIGIT, 1'b0, 8);
        wait_wrap();
        check("bands", 5'h02, {3'h0, band_code_hi, band_code_lo});
        check("raw bands", 5'h02, {3'h0, band_raw_hi, band_raw_lo});
        stall = 1;
        repeat (600) @(negedge core_clk);
        last = step_index;
        repeat (40) @(negedge core_clk);
        check("stalled step", last, step_index);
        stall = 0;
        preset_key = 1;
        @(negedge core_clk);
        check("clear", 5'h01, {4'h0, clear});
        wait_wrap();
        wait_wrap();
        preset_key = 0;
        @(negedge core_clk);
        check("clear", 5'h00, {4'h0, clear});
        preset_exp();
        read_freq();
        wait_wrap();
        for (int k = 0; k < 9; k++)
            check("sink", {1'b0, exp_d[k]}, {1'b0, partner.rx[k]});
        continuous = 0;
        wait_wrap();
        wait_step(5'd6);
        repeat (2) @(negedge core_clk);
        check("idle lanes", 5'h00, {1'b0, serial_out_w8, serial_out_w4,
            serial_out_w2, serial_out_w1});
        check("idle valid", 5'h00, {4'h0, serial_valid});
        continuous = 1;
        clock_enable = 0;
        repeat (12) @(negedge core_clk);
        repeat (2) begin
            last = step_index == 5'd17 ? 5'd0 : step_index + 5'd1;
            step_pulse = 1;
            @(negedge core_clk);
            step_pulse = 0;
            repeat (12) @(negedge core_clk);
            check("single step", last, step_index);
        end
        give_verdict();
    end
endmodule : testbench
